// ==== logic/timing_gen_defs.vh ====
/*
  constants for the machine cycle timing generator: clock rates,
  strobe delay, ring width and ring reset pattern.
  assumes inclusion by bare name from the design files.
*/
`ifndef TIMING_GEN_DEFS_VH
`define TIMING_GEN_DEFS_VH

// reference and core clock figures
`define REF_FREQ_MHZ 10
`define CORE_FREQ_MHZ 25
`define CORE_PERIOD_PS 40000
`define HALF_RATE_PERIOD_NS 200
`define QUARTER_RATE_PERIOD_NS 400

// strobe start delay after the half rate divider clears
`define STROBE_DELAY_NS 50
`define STROBE_DELAY_RAW ((`STROBE_DELAY_NS * 1000) / `CORE_PERIOD_PS)
`define STROBE_DELAY_CYC ((`STROBE_DELAY_RAW < 1) ? 1 : `STROBE_DELAY_RAW)

// slot and cycle figures
`define SLOT_NS 200
`define PAIR_SLOT_NS 400
`define MACHINE_CYCLE_NS 1600
`define RING_STAGES 8

// ring reset: stages 6 and 7 set, the state just before slot 0
`define RING_RESET 8'hC0
`define RING_CLEAR 8'h00
`define DIV_RESET 1'h0
`define BIT_ZERO 1'h0

`endif

// ==== logic/toggle_stage.v ====
/*
  one divide-by-two stage: toggles on every falling edge of its input.
  assumes the input is a level already in the i_core_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timing_gen_defs.vh"

module toggle_stage (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_src,
  output reg o_q
);

  reg src_prev_r;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_prev_r <= `DIV_RESET;
      o_q <= `DIV_RESET;
    end else begin
      src_prev_r <= i_src;
      // toggle on the falling edge of the input
      if (src_prev_r && !i_src) begin
        o_q <= ~o_q; // RULE_02
      end
    end
  end

endmodule // toggle_stage

`default_nettype wire

// ==== logic/machine_cycle_timing_generator.v ====
/*
  machine cycle timing generator: divider chain, ring clocks, time strobes,
  eight-stage self-correcting ring, slot, pair slot and late slot 7 pulses.
  assumes a free-running 10 MHz reference on i_ref_clk, asynchronous to
  i_core_clk, sampled at 25 MHz; all timing is quantised to 40 ns.
*/
// Notes on behaviour
// RULE_01 - all timing comes from the single 10 MHz reference input
// RULE_02 - each divider stage toggles on every falling edge of its input
// RULE_03 - half rate divider gives a 200 ns square wave
// RULE_04 - quarter rate divider gives a 400 ns square wave
// RULE_05 - ring clocks a and b are ANDs of the two divider outputs
// RULE_06 - time strobe and aux strobe are simultaneous, roughly 50 ns long
// RULE_07 - strobes start about 50 ns after the half rate divider clears
// RULE_08 - strobes end when the half rate divider sets again
// RULE_09 - eight slot pulses come in ascending order, locked to the reference
// RULE_10 - each slot rises exactly as the previous slot falls
// RULE_11 - slot 0 follows slot 7 at once, forever
// RULE_12 - each slot pulse is true for 200 ns
// RULE_13 - machine cycle is 1.6 us, slot 0 rise to slot 7 fall
// RULE_14 - pair slot pulses span two consecutive slots, 400 ns each
// RULE_15 - every timing output is active high
// RULE_16 - late slot 7 pulse is true in the last quarter of slot 7
// RULE_17 - ring of eight stages, two adjacent set, leapfrog on ring clocks
// RULE_18 - ring recovers from any state to two adjacent set stages
// RULE_19 - strobe delay comes from counting core clocks, not an analog delay
// RULE_20 - reset forces the ring to the state just before slot 0
`timescale 1ns/1ps
`default_nettype none
`include "timing_gen_defs.vh"

module machine_cycle_timing_generator #(
  parameter STROBE_DELAY_CYC = `STROBE_DELAY_CYC,
  parameter RING_STAGES = `RING_STAGES
) (
  input wire i_core_clk,
  input wire i_rstn,
  input wire i_ref_clk,
  output reg o_half_rate_divider,
  output reg o_quarter_rate_divider,
  output reg o_ring_clock_a,
  output reg o_ring_clock_b,
  output reg o_time_strobe,
  output reg o_aux_time_strobe,
  output reg [RING_STAGES-1:0] o_phase_slot,
  output reg [RING_STAGES-1:0] o_pair_slot,
  output reg o_late_slot7_pulse,
  output reg o_ring_valid
);

  // reference synchroniser
  reg ref_meta_r;
  reg ref_sync_r;

  // divider chain
  wire half_rate_divider;
  wire quarter_rate_divider;

  // ring clocks and their edge history
  wire ring_clock_a;
  wire ring_clock_b;
  reg ring_clock_a_prev_r;
  reg ring_clock_b_prev_r;
  wire ring_edge_a;
  wire ring_edge_b;

  // strobe delay line
  reg [STROBE_DELAY_CYC-1:0] strobe_dly_r;
  wire half_rate_cleared;
  wire strobe;

  // ring stages: stage i set means pair slot i,i+1 is active
  reg [RING_STAGES-1:0] ring_r;
  reg [RING_STAGES-1:0] ring_nxt;
  reg [RING_STAGES-1:0] slot_nxt;
  reg ring_valid_nxt;
  reg head_clear;
  integer k;
  integer j;
  integer m;
  integer set_count;
  integer adj_count;

  // the reference is asynchronous: two flops before anything reads it
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_meta_r <= `BIT_ZERO;
      ref_sync_r <= `BIT_ZERO;
    end else begin
      ref_meta_r <= i_ref_clk; // RULE_01
      ref_sync_r <= ref_meta_r;
    end
  end

  // first stage halves the reference
  toggle_stage u_half_rate (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_src(ref_sync_r),
    .o_q(half_rate_divider)
  ); // RULE_03

  // second stage halves the first
  toggle_stage u_quarter_rate (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_src(half_rate_divider),
    .o_q(quarter_rate_divider)
  ); // RULE_04

  // ring clocks alternate on each high half of the half rate divider
  assign ring_clock_a = half_rate_divider & quarter_rate_divider; // RULE_05
  assign ring_clock_b = half_rate_divider & ~quarter_rate_divider; // RULE_05

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ring_clock_a_prev_r <= `BIT_ZERO;
      ring_clock_b_prev_r <= `BIT_ZERO;
    end else begin
      ring_clock_a_prev_r <= ring_clock_a;
      ring_clock_b_prev_r <= ring_clock_b;
    end
  end

  // rising edges of the ring clocks
  assign ring_edge_a = ring_clock_a & ~ring_clock_a_prev_r;
  assign ring_edge_b = ring_clock_b & ~ring_clock_b_prev_r;

  // inverted half rate divider and its delayed copy
  assign half_rate_cleared = ~half_rate_divider;

  generate
    if (STROBE_DELAY_CYC > 1) begin : g_dly_long
      always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          strobe_dly_r <= {STROBE_DELAY_CYC{1'b0}};
        end else begin
          strobe_dly_r <= {strobe_dly_r[STROBE_DELAY_CYC-2:0], half_rate_cleared}; // RULE_19
        end
      end
    end else begin : g_dly_short
      always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          strobe_dly_r <= {STROBE_DELAY_CYC{1'b0}};
        end else begin
          strobe_dly_r <= half_rate_cleared; // RULE_19
        end
      end
    end
  endgenerate

  // strobe opens after the delay, closes as soon as the divider sets
  assign strobe = half_rate_cleared & strobe_dly_r[STROBE_DELAY_CYC-1]; // RULE_07 RULE_08

  // ring next state
  always @* begin
    ring_nxt = ring_r;
    // stage 0 loads only when stages 1..5 are all clear
    head_clear = 1'b1;
    for (k = 1; k < RING_STAGES - 2; k = k + 1) begin
      if (ring_r[k]) begin
        head_clear = 1'b0;
      end
    end
    // even stages move on ring clock a, odd stages on ring clock b
    for (k = 0; k < RING_STAGES; k = k + 1) begin
      if ((k % 2 == 0) ? ring_edge_a : ring_edge_b) begin
        if (k == 0) begin
          ring_nxt[k] = head_clear; // RULE_18
        end else begin
          ring_nxt[k] = ring_r[k-1]; // RULE_17
        end
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ring_r <= `RING_RESET; // RULE_20
    end else begin
      ring_r <= ring_nxt; // RULE_17
    end
  end

  // slot i is the overlap of stages i-1 and i
  always @* begin
    slot_nxt = {RING_STAGES{1'b0}};
    for (j = 0; j < RING_STAGES; j = j + 1) begin
      slot_nxt[j] = ring_r[(j + RING_STAGES - 1) % RING_STAGES] & ring_r[j]; // RULE_09 RULE_10
    end
  end

  // ring health: exactly two stages set and they are neighbours
  always @* begin
    set_count = 0;
    adj_count = 0;
    for (m = 0; m < RING_STAGES; m = m + 1) begin
      if (ring_r[m]) begin
        set_count = set_count + 1;
      end
      if (ring_r[m] && ring_r[(m + 1) % RING_STAGES]) begin
        adj_count = adj_count + 1;
      end
    end
    ring_valid_nxt = (set_count == 2) && (adj_count == 1);
  end

  // every output is registered, all with the same one clock lag
  // half rate divider output
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_half_rate_divider <= `BIT_ZERO;
    end else begin
      o_half_rate_divider <= half_rate_divider; // RULE_15
    end
  end

  // quarter rate divider output
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_quarter_rate_divider <= `BIT_ZERO;
    end else begin
      o_quarter_rate_divider <= quarter_rate_divider; // RULE_15
    end
  end

  // ring clock a output
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ring_clock_a <= `BIT_ZERO;
    end else begin
      o_ring_clock_a <= ring_clock_a; // RULE_05
    end
  end

  // ring clock b output
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ring_clock_b <= `BIT_ZERO;
    end else begin
      o_ring_clock_b <= ring_clock_b; // RULE_05
    end
  end

  // main time strobe
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_time_strobe <= `BIT_ZERO;
    end else begin
      o_time_strobe <= strobe; // RULE_06
    end
  end

  // aux time strobe, its own flop
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_aux_time_strobe <= `BIT_ZERO;
    end else begin
      o_aux_time_strobe <= strobe; // RULE_06
    end
  end

  // slot pulses
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_phase_slot <= {RING_STAGES{1'b0}};
    end else begin
      o_phase_slot <= slot_nxt; // RULE_11 RULE_12 RULE_13
    end
  end

  // pair slot pulses
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pair_slot <= {RING_STAGES{1'b0}};
    end else begin
      o_pair_slot <= ring_r; // RULE_14
    end
  end

  // last quarter of slot 7 coincides with the strobe window
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_late_slot7_pulse <= `BIT_ZERO;
    end else begin
      o_late_slot7_pulse <= slot_nxt[RING_STAGES-1] & strobe; // RULE_16
    end
  end

  // ring health flag
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ring_valid <= `BIT_ZERO;
    end else begin
      o_ring_valid <= ring_valid_nxt; // RULE_18
    end
  end

endmodule // machine_cycle_timing_generator

`default_nettype wire

// ==== tb/mctg_asserts.sv ====
/*
  port checker for the machine cycle timing generator.
  assumes a bind to the top module, one clock, asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mctg_asserts (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic o_half_rate_divider,
  input wire logic o_quarter_rate_divider,
  input wire logic o_ring_clock_a,
  input wire logic o_ring_clock_b,
  input wire logic o_time_strobe,
  input wire logic o_aux_time_strobe,
  input wire logic [7:0] o_phase_slot,
  input wire logic [7:0] o_pair_slot,
  input wire logic o_late_slot7_pulse,
  input wire logic o_ring_valid
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic [3:0] len_r;
  logic [1:0] run_r;
  // cycles since the last slot change, skipping the partial first slot
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      len_r <= 4'h0;
      run_r <= 2'h0;
    end else if ($changed(o_phase_slot)) begin
      len_r <= 4'h1;
      if (run_r != 2'h2) run_r <= run_r + 2'h1;
    end else if (len_r != 4'hF) begin
      len_r <= len_r + 4'h1;
    end
  end
  a_half_period: assert property ($changed(o_half_rate_divider) |=>
    !$changed(o_half_rate_divider) ##[1:2] $changed(o_half_rate_divider))
    else $error("half divider phase length off");
  a_quarter_step: assert property ($changed(o_quarter_rate_divider) |->
    $past(o_half_rate_divider, 2) && !$past(o_half_rate_divider))
    else $error("quarter divider moved off half fall");
  a_ring_apart: assert property (!(o_ring_clock_a && o_ring_clock_b))
    else $error("ring clocks overlap");
  a_strobe_twin: assert property (o_time_strobe == o_aux_time_strobe)
    else $error("strobes differ");
  a_strobe_start: assert property ($fell(o_half_rate_divider) |->
    !o_time_strobe ##1 o_time_strobe) else $error("strobe start wrong");
  a_strobe_end: assert property (o_time_strobe |-> !o_half_rate_divider)
    else $error("strobe while half divider set");
  a_slot_order: assert property (run_r == 2'h2 && $changed(o_phase_slot) |->
    {o_phase_slot[0], o_phase_slot[7:1]} == $past(o_phase_slot))
    else $error("slot did not advance by one");
  a_slot_length: assert property (run_r == 2'h2 && $changed(o_phase_slot) |->
    len_r >= 4'h4 && len_r <= 4'h6) else $error("slot length off");
  a_pair_slot: assert property (o_phase_slot ==
    (o_pair_slot & {o_pair_slot[6:0], o_pair_slot[7]})) else $error("pair slot mismatch");
  a_ring_valid: assert property ($past(i_rstn) |-> o_ring_valid &&
    $onehot(o_phase_slot)) else $error("ring not valid");
  a_late_slot7: assert property (o_late_slot7_pulse |->
    o_phase_slot[7] && o_time_strobe) else $error("late slot 7 pulse misplaced");
endmodule // mctg_asserts
`default_nettype wire

// ==== tb/ref_source.sv ====
/*
  free running 10 MHz reference for the bench.
  assumes nothing; its phase is unrelated to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_source (
  output var logic o_ref
);
  initial begin
    o_ref = 1'b0;
    #13;
    forever #50 o_ref = ~o_ref;
  end
endmodule // ref_source
`default_nettype wire

// ==== tb/machine_cycle_timing_generator_bench.sv ====
/*
  bench for the machine cycle timing generator: reset, slot order,
  strobe and divider counts, mid-run reset.
  assumes the reference model and the port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module machine_cycle_timing_generator_bench;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  wire logic rf, h, q, ca, cb, ts, aux_time_strobe, lt, vld;
  wire logic [7:0] ps, pr;
  int fails = 0;
  int num_checks = 0;
  always #20 i_core_clk = ~i_core_clk;
  ref_source osc (.o_ref(rf));
  machine_cycle_timing_generator DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_ref_clk(rf), .o_half_rate_divider(h), .o_quarter_rate_divider(q),
    .o_ring_clock_a(ca), .o_ring_clock_b(cb), .o_time_strobe(ts),
    .o_aux_time_strobe(aux_time_strobe), .o_phase_slot(ps), .o_pair_slot(pr),
    .o_late_slot7_pulse(lt), .o_ring_valid(vld));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic next_slot(output int n);
    logic [7:0] s;
    s = ps;
    n = 0;
    while (ps === s && n < 20) begin
      step(1);
      n++;
    end
    if (n == 20) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset(input int n);
    i_rstn = 1'b0;
    step(n);
    `CHK(ps, 8'h00)
    `CHK(ts, 1'b0)
    i_rstn = 1'b1;
    step(1);
    `CHK(pr, 8'hC0)
    `CHK(ps, 8'h80)
    `CHK(vld, 1'b1)
  endtask
  task automatic t_cycle();
    int n;
    int t;
    for (int i = 0; i < 10 && ps !== 8'h01; i++) next_slot(n);
    `CHK(ps, 8'h01)
    t = 0;
    for (int k = 1; k <= 8; k++) begin
      next_slot(n);
      t += n;
      `CHK(ps, 8'h01 << (k % 8))
      `CHK(pr[0], (k % 8) < 2)
    end
    `CHK(t, 40)
  endtask
  task automatic t_counts();
    int lo, st, th, tq;
    logic ph, pq;
    bit sa, sb, sl;
    lo = 0;
    st = 0;
    th = 0;
    tq = 0;
    sa = 1'b0;
    sb = 1'b0;
    sl = 1'b0;
    ph = h;
    pq = q;
    repeat (40) begin
      step(1);
      `CHK(aux_time_strobe, ts)
      lo += !h;
      st += ts;
      th += (h !== ph);
      tq += (q !== pq);
      ph = h;
      pq = q;
      sa |= ca;
      sb |= cb;
      sl |= lt;
    end
    `CHK(th, 16)
    `CHK(tq, 8)
    `CHK(st, lo - 8)
    `CHK(sa & sb, 1'b1)
    `CHK(sl, 1'b1)
  endtask
  initial begin
    t_reset(12);
    t_cycle();
    t_counts();
    step(7);
    t_reset(2);
    t_cycle();
    t_counts();
    tally_and_finish();
  end
endmodule // machine_cycle_timing_generator_bench
bind machine_cycle_timing_generator mctg_asserts chk (.i_core_clk(i_core_clk),
  .i_rstn(i_rstn), .o_half_rate_divider(o_half_rate_divider),
  .o_quarter_rate_divider(o_quarter_rate_divider), .o_ring_clock_a(o_ring_clock_a),
  .o_ring_clock_b(o_ring_clock_b), .o_time_strobe(o_time_strobe),
  .o_aux_time_strobe(o_aux_time_strobe), .o_phase_slot(o_phase_slot),
  .o_pair_slot(o_pair_slot), .o_late_slot7_pulse(o_late_slot7_pulse),
  .o_ring_valid(o_ring_valid));
`default_nettype wire
